/* File: verilog/dcr_top.sv */
// dcr_top: control registers and sleep handling of the 10-bit converter
//
// Operation
// RULE_01 - control bit 0 set enables the converter
// RULE_02 - control bit 6 drives buffer to pin
// RULE_03 - standby_run keeps converter running in standby
// RULE_04 - ten-bit value split across two byte lanes
// RULE_05 - output changes only on high-byte write
// RULE_06 - value sits at view bits 15:6
// RULE_07 - start on write if enabled, else later
// RULE_08 - control bit 0 cleared disables converter
// RULE_09 - standby without standby_run stops, exit restarts
// RULE_10 - power-down always stops converter and buffer
// RULE_11 - low byte held, ten bits land together
module dcr_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_standby,
    input wire logic sleep_powerdown,
    output logic [9:0] dac_code,
    output logic dac_enable,
    output logic dac_buffer_enable,
    output logic dac_conv_start
);
    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the map needs index 4, i.e. byte address 0x10, so five bits
    generate
        if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
            $error("dcr_top: ADDR_W must lie between 5 and 32");
        end
    endgenerate

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic enable; // software enable
        logic buffer_output_enable; // buffer_output_enable
        logic stdby_run; // standby_run
        logic [1:0] hold_lo; // value_low_byte holding stage
        logic [7:0] data_hi; // value_high_byte as written
        logic [9:0] code; // code applied to the converter
        logic conv_en; // converter powered and running
        logic buf_en; // output buffer powered
        logic start; // one-cycle conversion start
    } dcr_core_s;

    dcr_core_s q; // registered state
    dcr_core_s d; // next state

    // register strobes and views shared with the bus slave
    dcr_if regs ();

    // ************************************************************
    // bus slave
    // ************************************************************
    // the slave owns prdata, pready and pslverr flip-flops
    dcr_apb #(
        .ADDR_W(ADDR_W)
    ) u_apb (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .regs(regs)
    );

    // ************************************************************
    // sleep gating
    // ************************************************************
    // standby stops the converter only when standby_run is clear;
    // power-down stops it whatever standby_run says
    function automatic logic may_run(input logic en, input logic run_sb,
                                     input logic sb, input logic pd);
        logic res;
        res = en; // RULE_01 RULE_08
        if (sb && !run_sb) begin
            res = 1'b0; // RULE_09
        end
        if (pd) begin
            res = 1'b0; // RULE_10
        end
        return res;
    endfunction

    logic run_now; // converter allowed to run next cycle
    logic [1:0] lo_next; // low code bits after this cycle's writes

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        d = q;
        d.start = 1'b0;
        lo_next = q.hold_lo;

        // control write: the three documented bits only
        if (regs.wr_ctrl) begin
            d.enable = regs.wdata[dcr_pkg::CTRL_ENABLE_BIT]; // RULE_01 RULE_08
            d.buffer_output_enable = regs.wdata[dcr_pkg::CTRL_BUFFER_OUTPUT_ENABLE_BIT]; // RULE_02
            d.stdby_run = regs.wdata[dcr_pkg::CTRL_STDBY_BIT]; // RULE_03
        end

        // low byte goes to the holding stage, output untouched
        if (regs.wr_lo) begin
            lo_next = regs.wdata[dcr_pkg::LO_POS +: dcr_pkg::LO_BITS]; // RULE_11
        end
        d.hold_lo = lo_next;

        // high byte commits all ten bits at once; a write that carries
        // both lanes uses the new low bits as well
        if (regs.wr_hi) begin
            d.data_hi = regs.wdata[dcr_pkg::HI_BITS +: dcr_pkg::HI_BITS]; // RULE_04
            d.code = {d.data_hi, lo_next}; // RULE_05 RULE_11
        end

        // power state follows the new control bits in the same edge
        run_now = may_run(d.enable, d.stdby_run, sleep_standby,
                          sleep_powerdown); // RULE_03 RULE_09 RULE_10
        d.conv_en = run_now;
        // buffer only with the converter, and only if buffer_output_enable is set
        d.buf_en = run_now && d.buffer_output_enable; // RULE_02 RULE_09

        // start on a high write while running; a write while stopped
        // waits for the converter to come up (enable or sleep exit)
        d.start = run_now && (regs.wr_hi || !q.conv_en); // RULE_07 RULE_09
    end

    // ************************************************************
    // state register
    // ************************************************************
    // ce low freezes everything, a pending start pulse included
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '{enable: dcr_pkg::CTRL_RESET[dcr_pkg::CTRL_ENABLE_BIT],
                   buffer_output_enable: dcr_pkg::CTRL_RESET[dcr_pkg::CTRL_BUFFER_OUTPUT_ENABLE_BIT],
                   stdby_run: dcr_pkg::CTRL_RESET[dcr_pkg::CTRL_STDBY_BIT],
                   hold_lo: dcr_pkg::VALUE_RESET[dcr_pkg::LO_POS +: dcr_pkg::LO_BITS],
                   data_hi: dcr_pkg::VALUE_RESET[dcr_pkg::HI_BITS +: dcr_pkg::HI_BITS],
                   code: dcr_pkg::VALUE_RESET[dcr_pkg::VALUE_LSB +: dcr_pkg::VALUE_W],
                   conv_en: 1'b0,
                   buf_en: 1'b0,
                   start: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    // ************************************************************
    // read views
    // ************************************************************
    // control reads back the three bits, the rest as zero
    always_comb begin
        regs.rd_ctrl = dcr_pkg::CTRL_RESET;
        regs.rd_ctrl[dcr_pkg::CTRL_ENABLE_BIT] = q.enable;
        regs.rd_ctrl[dcr_pkg::CTRL_BUFFER_OUTPUT_ENABLE_BIT] = q.buffer_output_enable;
        regs.rd_ctrl[dcr_pkg::CTRL_STDBY_BIT] = q.stdby_run;
    end

    // value view: code at 15:6, bits 5:0 always zero; the low bits
    // shown are the holding stage, so a read after a lone low write
    // shows what the next high write will commit
    always_comb begin
        regs.rd_value = dcr_pkg::VALUE_RESET;
        regs.rd_value[dcr_pkg::HI_BITS +: dcr_pkg::HI_BITS] = q.data_hi; // RULE_06
        regs.rd_value[dcr_pkg::LO_POS +: dcr_pkg::LO_BITS] = q.hold_lo; // RULE_06
    end

    // live state for software: running, buffer, held by sleep
    always_comb begin
        regs.rd_status = dcr_pkg::CTRL_RESET;
        regs.rd_status[dcr_pkg::ST_ACTIVE_BIT] = q.conv_en;
        regs.rd_status[dcr_pkg::ST_BUFFER_BIT] = q.buf_en;
        regs.rd_status[dcr_pkg::ST_HELD_BIT] = q.enable && !q.conv_en;
    end

    // ************************************************************
    // outputs, straight from flip-flops
    // ************************************************************
    assign dac_code = q.code;
    assign dac_enable = q.conv_en;
    assign dac_buffer_enable = q.buf_en;
    assign dac_conv_start = q.start;
endmodule

/* File: pkg/dcr_pkg.sv */
// dcr_pkg: register map, field layout and reset values of the converter control block
package dcr_pkg;
    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam int IDX_CTRL = 0; // converter_control
    localparam int IDX_RSVD = 1; // reserved, reads zero
    localparam int IDX_VALUE = 2; // converter_value, 16-bit view
    localparam int IDX_STATUS = 4; // live converter state, read only
    localparam int BYTE_PER_WORD = 4; // one aligned word per register

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int CTRL_ENABLE_BIT = 0; // converter enable
    localparam int CTRL_BUFFER_OUTPUT_ENABLE_BIT = 6; // buffer_output_enable
    localparam int CTRL_STDBY_BIT = 7; // standby_run
    localparam int VALUE_W = 10; // converter code width
    localparam int VALUE_LSB = 6; // code sits at view bits 15:6
    localparam int LO_BITS = 2; // code bits held in the low byte
    localparam int LO_POS = 6; // low-byte position of code bits 1:0
    localparam int HI_BITS = 8; // code bits held in the high byte
    localparam int LANE_LO = 0; // byte lane of value_low_byte
    localparam int LANE_HI = 1; // byte lane of value_high_byte
    localparam int ST_ACTIVE_BIT = 0; // status: converter running
    localparam int ST_BUFFER_BIT = 1; // status: output buffer on
    localparam int ST_HELD_BIT = 2; // status: stopped by sleep

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

/* File: pkg/dcr_if.sv */
// dcr_if: register strobes and read views between the bus slave and the core
interface dcr_if;
    logic wr_ctrl; // write to converter_control, low lane
    logic wr_lo; // write to value_low_byte
    logic wr_hi; // write to value_high_byte
    logic [15:0] wdata; // low half of the bus write data
    logic [7:0] rd_ctrl; // converter_control as read back
    logic [15:0] rd_value; // converter_value as read back
    logic [7:0] rd_status; // live state of the converter

    // bus side drives strobes, reads the views
    modport apb_side (
        output wr_ctrl,
        output wr_lo,
        output wr_hi,
        output wdata,
        input rd_ctrl,
        input rd_value,
        input rd_status
    );
    // core side takes strobes, drives the views
    modport core_side (
        input wr_ctrl,
        input wr_lo,
        input wr_hi,
        input wdata,
        output rd_ctrl,
        output rd_value,
        output rd_status
    );
endinterface

/* File: verilog/dcr_apb.sv */
// dcr_apb: apb slave with one wait state, address decode and read mux
module dcr_apb #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dcr_if.apb_side regs
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        DCR_ST_IDLE = 2'b01, // waiting for an access phase
        DCR_ST_DONE = 2'b10 // answer on the bus this cycle
    } dcr_apb_e;

    typedef struct packed {
        dcr_apb_e st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dcr_apb_s;

    dcr_apb_s q; // registered state
    dcr_apb_s d; // next state

    // true when the address is aligned and names the given index
    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input int idx);
        return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    // true for any mapped word; the rest answer with an error
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return is_reg(a, dcr_pkg::IDX_CTRL) || is_reg(a, dcr_pkg::IDX_RSVD)
            || is_reg(a, dcr_pkg::IDX_VALUE) || is_reg(a, dcr_pkg::IDX_STATUS);
    endfunction

    // ************************************************************
    // write strobes: only at the edge where pready is sampled high
    // ************************************************************
    logic commit; // completing mapped write
    assign commit = psel && penable && q.pready && pwrite && is_mapped(paddr);
    assign regs.wr_ctrl = commit && is_reg(paddr, dcr_pkg::IDX_CTRL)
                          && pstrb[dcr_pkg::LANE_LO];
    assign regs.wr_lo = commit && is_reg(paddr, dcr_pkg::IDX_VALUE)
                        && pstrb[dcr_pkg::LANE_LO]; // RULE_04
    assign regs.wr_hi = commit && is_reg(paddr, dcr_pkg::IDX_VALUE)
                        && pstrb[dcr_pkg::LANE_HI]; // RULE_04
    assign regs.wdata = pwdata[15:0];

    // next state: answer one cycle after the access phase opens
    always_comb begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        case (q.st)
            DCR_ST_IDLE: begin
                if (psel && penable) begin
                    d.st = DCR_ST_DONE;
                    d.pready = 1'b1;
                    d.pslverr = !is_mapped(paddr);
                    d.prdata = dcr_pkg::RDATA_RESET;
                    // reads only; reserved and unmapped words give zero
                    if (!pwrite && is_reg(paddr, dcr_pkg::IDX_CTRL)) begin
                        d.prdata[7:0] = regs.rd_ctrl;
                    end else if (!pwrite && is_reg(paddr, dcr_pkg::IDX_VALUE)) begin
                        d.prdata[15:0] = regs.rd_value;
                    end else if (!pwrite && is_reg(paddr, dcr_pkg::IDX_STATUS)) begin
                        d.prdata[7:0] = regs.rd_status;
                    end
                end
            end
            DCR_ST_DONE: begin
                d.st = DCR_ST_IDLE; // pready drops after one cycle
            end
            default: begin
                d.st = DCR_ST_IDLE;
            end
        endcase
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '{st: DCR_ST_IDLE, pready: 1'b0, pslverr: 1'b0,
                   prdata: dcr_pkg::RDATA_RESET};
        end else if (ce) begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
endmodule

/* File: tb/dcr_top_asserts.sv */
// dcr_top_asserts: port-level checks of the converter control block
module dcr_top_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_standby,
    input wire logic sleep_powerdown,
    input wire logic [9:0] dac_code,
    input wire logic dac_enable,
    input wire logic dac_buffer_enable,
    input wire logic dac_conv_start
);
    // ****
    // shadow of control byte and held low bits
    // ****
    logic [7:0] ctl_q; // last control byte written
    logic [1:0] lo_q; // last low bits written
    logic acc; // good write completes now
    logic wr_ctl;
    logic wr_lo;
    logic wr_hi;
    logic [7:0] ctl_c;
    logic [1:0] lo_c;
    logic run_c; // run condition after this edge
    assign acc = ce && psel && penable && pwrite && pready && !pslverr;
    assign wr_ctl = acc && paddr == ADDR_W'(0) && pstrb[0];
    assign wr_lo = acc && paddr == ADDR_W'(8) && pstrb[0];
    assign wr_hi = acc && paddr == ADDR_W'(8) && pstrb[1];
    assign ctl_c = wr_ctl ? pwdata[7:0] : ctl_q;
    assign lo_c = wr_lo ? pwdata[7:6] : lo_q;
    // standby only stops us when standby_run is clear
    assign run_c = ctl_c[0] && !sleep_powerdown && !(sleep_standby && !ctl_c[7]);
    // shadow registers, cleared with the design
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            lo_q <= 2'h0;
        end else begin
            ctl_q <= ctl_c;
            lo_q <= lo_c;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus handshake and converter rise steps
    sequence s_setup;
        ce && psel && !penable;
    endsequence
    sequence s_rise;
        !dac_enable ##1 dac_enable;
    endsequence
    a_one_wait: assert property (s_setup ##1 (ce && penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("unaligned access not refused");
    a_enable_run: assert property (ce |=> dac_enable == $past(run_c))
        else $error("converter enable wrong");
    a_buffer_run: assert property (ce |=> dac_buffer_enable == $past(run_c && ctl_c[6]))
        else $error("buffer enable wrong");
    a_start_high: assert property (ce && wr_hi && run_c |=> dac_conv_start)
        else $error("no start on value write");
    a_no_start: assert property (ce && !run_c |=> !dac_conv_start)
        else $error("start while stopped");
    a_start_rise: assert property (s_rise |-> dac_conv_start)
        else $error("no start when converter comes up");
    a_code_high: assert property (ce && wr_hi |=> dac_code == {$past(pwdata[15:8]), $past(lo_c)})
        else $error("code not committed from both bytes");
    a_code_hold: assert property (ce && !wr_hi |=> $stable(dac_code))
        else $error("code moved without high write");
endmodule
bind dcr_top dcr_top_asserts #(.ADDR_W(ADDR_W)) dcr_top_asserts_i (.clk(clk), .rst_n(rst_n),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_standby(sleep_standby), .sleep_powerdown(sleep_powerdown), .dac_code(dac_code),
    .dac_enable(dac_enable), .dac_buffer_enable(dac_buffer_enable),
    .dac_conv_start(dac_conv_start));

/* File: tb/dcr_top_tb.sv */
// dcr_top_tb: register-level test of the converter control block
module dcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_VAL = 8'(dcr_pkg::IDX_VALUE * dcr_pkg::BYTE_PER_WORD);
    localparam logic [7:0] A_RSV = 8'(dcr_pkg::IDX_RSVD * dcr_pkg::BYTE_PER_WORD);
    localparam logic [7:0] A_ST = 8'(dcr_pkg::IDX_STATUS * dcr_pkg::BYTE_PER_WORD);
    logic clk = 1'b0; // 25 MHz
    logic rst_n = 1'b0;
    logic ce = 1'b1; // dropped once to check the freeze
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic sb = 1'b0; // standby request
    logic pd = 1'b0; // power-down request
    logic [31:0] prdata;
    logic pready, pslverr, dac_enable, dac_buffer_enable, dac_conv_start;
    logic [9:0] dac_code;
    logic [31:0] rd_q; // data of last transfer
    logic err_q; // error of last transfer
    int error_cnt = 0;
    int num_checks = 0;
    int starts = 0; // start pulses seen
    dcr_top dcr_top_i (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_standby(sb), .sleep_powerdown(pd),
        .dac_code(dac_code), .dac_enable(dac_enable), .dac_buffer_enable(dac_buffer_enable),
        .dac_conv_start(dac_conv_start));
    always #20 clk = ~clk;
    // counted mid-cycle so a pulse is never raced
    always @(negedge clk) if (dac_conv_start === 1'b1) starts++;
    // ****
    // verdict and compare
    // ****
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // ****
    // bus and sleep drivers
    // ****
    // one transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: bus hang", $time);
            end_sim();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic e);
        apb(1'b1, a, d, s);
        chk({31'h0, err_q}, {31'h0, e}, "write error");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd_q, x, "read data");
        chk({31'h0, err_q}, {31'h0, e}, "read error");
    endtask
    // outputs react one edge after the sleep inputs
    task automatic slp(input logic s, input logic p);
        sb <= s;
        pd <= p;
        repeat (2) @(posedge clk);
    endtask
    task automatic outs(input logic [9:0] c, input logic e, input logic b, input int st);
        chk({20'h0, dac_code, dac_enable, dac_buffer_enable}, {20'h0, c, e, b}, "outputs");
        chk(32'(starts), 32'(st), "start count");
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        outs(10'h000, 0, 0, 0);
        rd(8'h00, 32'h0, 0);
        rd(A_VAL, 32'h0, 0);
        rd(A_RSV, 32'h0, 0);
        $display("test reset done");
        wr(A_VAL, 32'h0000_00C0, 4'h1, 0);
        outs(10'h000, 0, 0, 0);
        rd(A_VAL, 32'h0000_00C0, 0);
        wr(A_VAL, 32'h0000_A500, 4'h2, 0);
        outs(10'h297, 0, 0, 0);
        rd(A_VAL, 32'h0000_A5C0, 0);
        wr(8'h00, 32'h01, 4'h1, 0);
        outs(10'h297, 1, 0, 1);
        rd(A_ST, 32'h01, 0);
        wr(8'h00, 32'h41, 4'h1, 0);
        outs(10'h297, 1, 1, 1);
        wr(A_VAL, 32'h0000_3C40, 4'h3, 0);
        outs(10'h0F1, 1, 1, 2);
        $display("test value done");
        slp(1, 0);
        outs(10'h0F1, 0, 0, 2);
        slp(0, 0);
        outs(10'h0F1, 1, 1, 3);
        wr(8'h00, 32'hC1, 4'h1, 0);
        slp(1, 0);
        outs(10'h0F1, 1, 1, 3);
        slp(1, 1);
        outs(10'h0F1, 0, 0, 3);
        slp(0, 0);
        outs(10'h0F1, 1, 1, 4);
        wr(8'h00, 32'h40, 4'h1, 0);
        outs(10'h0F1, 0, 0, 4);
        rd(8'h00, 32'h40, 0);
        $display("test sleep done");
        wr(8'h01, 32'hFF, 4'hF, 1);
        wr(8'h0C, 32'hFF, 4'hF, 1);
        wr(A_RSV, 32'hFF, 4'hF, 0);
        rd(A_RSV, 32'h0, 0);
        rd(8'h0C, 32'h0, 1);
        $display("test errors done");
        wr(8'h00, 32'h41, 4'h1, 0);
        outs(10'h0F1, 1, 1, 5);
        // with ce low a standby request must not reach the outputs
        ce <= 1'b0;
        slp(1, 0);
        outs(10'h0F1, 1, 1, 5);
        slp(0, 0);
        ce <= 1'b1;
        slp(0, 0);
        outs(10'h0F1, 1, 1, 5);
        $display("test freeze done");
        end_sim();
    end
endmodule
